// File: cvd_pkg.sv
`default_nettype none
package cvd_pkg;
  // clocking: instruction cycle of the pre-charge and acquisition timers
  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam int unsigned TCY_NS      = 200;
  localparam int unsigned TCY_CYC     = (TCY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned TCY_W       = 6;
  localparam logic [TCY_W-1:0] TCY_LAST = TCY_W'(TCY_CYC - 1);
  localparam logic        GAP_LAST    = 1'b1; // two cycles between the samples

  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES0L = 8'h08;
  localparam logic [7:0] OFS_RES0H = 8'h0C;
  localparam logic [7:0] OFS_RES1L = 8'h10;
  localparam logic [7:0] OFS_RES1H = 8'h14;
  localparam logic [7:0] OFS_IRQEN = 8'h18;
  localparam logic [7:0] OFS_IRQFL = 8'h1C;
  localparam logic [7:0] OFS_PRE   = 8'h20;
  localparam logic [7:0] OFS_ACQ   = 8'h24;
  localparam logic [7:0] OFS_CVD   = 8'h28;
  localparam logic [7:0] OFS_STAT  = 8'h2C;

  // field positions
  localparam int unsigned B_ON     = 0;
  localparam int unsigned B_GO     = 1;
  localparam int unsigned B_CHAN   = 2;
  localparam int unsigned B_JUST   = 7;
  localparam int unsigned B_CLKSEL = 4;
  localparam int unsigned B_PREF   = 0;
  localparam int unsigned B_DONE   = 6;
  localparam int unsigned B_DSEN   = 0;
  localparam int unsigned B_IPEN   = 1;
  localparam int unsigned B_IPPOL  = 2;
  localparam int unsigned B_EPPOL  = 3;
  localparam int unsigned B_GRDPOL = 4;
  localparam int unsigned B_GAOE   = 5;
  localparam int unsigned B_GBOE   = 6;

  // reset values and encodings
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RES_RST    = 8'h00;
  localparam logic       JUST_RIGHT = 1'b1;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE  = 3'b001,
    ST_ACQ  = 3'b010,
    ST_CONV = 3'b011,
    ST_GAP  = 3'b100
  } cvd_state_t;
endpackage : cvd_pkg
`default_nettype wire

// File: cvd_result_pair.sv
`default_nettype none
module cvd_result_pair
  import cvd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic       justify_i,
  input  wire logic [9:0] data_i,
  input  wire logic       wr_lo_i,
  input  wire logic       wr_hi_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] lo_o,
  output logic      [7:0] hi_o
);
  // a conversion load beats a software write: the fresh result must not be lost
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_o <= RES_RST;
      hi_o <= RES_RST;
    end else if (load_i) begin
      if (justify_i == JUST_RIGHT) begin
        hi_o <= {6'h00, data_i[9:8]};
        lo_o <= data_i[7:0];
      end else begin
        hi_o <= data_i[9:2];
        lo_o <= {data_i[1:0], 6'h00};
      end
    end else begin
      if (wr_lo_i) begin
        lo_o <= wdata_i;
      end
      if (wr_hi_i) begin
        hi_o <= wdata_i;
      end
    end
  end

  property p_left_fmt;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    load_i && justify_i != JUST_RIGHT |=> lo_o == {$past(data_i[1:0]), 6'h00} && hi_o == $past(data_i[9:2]);
  endproperty
  a_left_fmt: assert property (p_left_fmt) else $error("left-justified result misplaced");

  property p_right_fmt;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    load_i && justify_i == JUST_RIGHT |=> {hi_o, lo_o} == {6'h00, $past(data_i)};
  endproperty
  a_right_fmt: assert property (p_right_fmt) else $error("right-justified result misplaced");
endmodule : cvd_result_pair
`default_nettype wire

// File: cvd_phase_timer.sv
`default_nettype none
module cvd_phase_timer
  import cvd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       load_i,
  input  wire logic [6:0] count_i,
  input  wire logic       tick_i,
  output logic            expired_o
);
  logic [6:0] remain_r;

  // counts whole instruction cycles down to zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain_r <= 7'h00;
    end else if (ce_i) begin
      if (load_i) begin
        remain_r <= count_i;
      end else if (tick_i && remain_r != 7'h00) begin
        remain_r <= remain_r - 7'h01;
      end
    end
  end

  assign expired_o = (remain_r == 7'h00);

  property p_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && load_i |=> remain_r == $past(count_i);
  endproperty
  a_load: assert property (p_load) else $error("phase timer did not load its count");
endmodule : cvd_phase_timer
`default_nettype wire

// File: cvd_sequencer.sv
// Summary of operation
// - left-justified: result bits 1..0 go to low byte bits 7..6, rest zero.
// - right-justified: result bits 9..8 go to high byte bits 1..0.
// - right-justified: result bits 7..0 fill the low byte.
// - hold capacitor is never discharged after a conversion.
// - sensing works on any selected channel against the internal hold capacitance.
// - pre-charge isolates and biases the hold capacitor, drives the sensor pin.
// - end of pre-charge releases drives, reconnects capacitor, acquisition begins.
// - after acquisition the settled hold voltage is converted.
// - differential pass repeats the sequence with both pre-charge levels inverted.
// - double sample writes two result pairs, second sample inverted.
// - two guard-ring outputs follow the sensing sequence.
// - pre-charge lasts 1..127 instruction cycles; zero skips it.
// - acquisition lasts 1..127 instruction cycles, after pre-charge or trigger.
// - completion clears busy, sets the done flag, loads the results.
// - unused result bits are forced to zero on load.
//
// Chosen here: register access over AHB-Lite and the address map.
`default_nettype none
module cvd_sequencer
  import cvd_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  output logic      [31:0] hrdata_o,
  input  wire logic        trig_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_start_o,
  output logic             converter_on_o,
  output logic      [4:0]  input_channel_select_o,
  output logic      [2:0]  conversion_clock_select_o,
  output logic      [1:0]  positive_ref_select_o,
  output logic             hold_connect_o,
  output logic             hold_bias_en_o,
  output logic             hold_bias_level_o,
  output logic             sense_drive_o,
  output logic             sense_drive_oe_o,
  output logic             guard_a_o,
  output logic             guard_a_oe_o,
  output logic             guard_b_o,
  output logic             guard_b_oe_o
);
  cvd_state_t state_r;
  cvd_state_t state_nxt;
  logic       second_r;
  logic       second_nxt;
  logic       on_r;
  logic       go_r;
  logic [4:0] chan_sel_r;
  logic       just_r;
  logic [2:0] clksel_r;
  logic [1:0] pref_r;
  logic       irqen_r;
  logic       flag_r;
  logic [6:0] pre_cnt_r;
  logic [6:0] acq_cnt_r;
  logic [6:0] cvd_r;
  logic       gap_r;
  logic [TCY_W-1:0] tcy_r;
  logic       rd_wait_r;
  logic [7:0] rd_addr_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [7:0] res0l;
  logic [7:0] res0h;
  logic [7:0] res1l;
  logic [7:0] res1h;
  logic [7:0] rd_mux;
  logic       ap_take;
  logic       wr_act;
  logic       wr_ctrl0;
  logic       go_set_wr;
  logic       go_clr_wr;
  logic       start;
  logic       abort;
  logic       fin;
  logic       first_done;
  logic       tick;
  logic       expired;
  logic       tmr_load;
  logic       inv_nxt;
  logic       dsen;
  logic       ipen;
  cvd_state_t first_phase;

  // bus decode; writes land in the data phase with hwdata
  assign ap_take   = hsel_i && hready_i && htrans_i[1];
  assign wr_act    = ce_i && wr_pend_r;
  assign wr_ctrl0  = wr_act && wr_addr_r == OFS_CTRL0;
  // start needs the converter already on, so on and go in one write starts nothing
  assign go_set_wr = wr_ctrl0 && hwdata_i[B_GO] && on_r;
  assign go_clr_wr = wr_ctrl0 && !hwdata_i[B_GO] && go_r;
  assign dsen      = cvd_r[B_DSEN];
  assign ipen      = cvd_r[B_IPEN];

  // reads take one wait state so a write just before is always visible
  assign hreadyout_o = ce_i && !rd_wait_r;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = rdata_r;

  // address phase capture
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_wait_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_addr_r <= 8'h00;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_wait_r <= ap_take && !hwrite_i;
      wr_pend_r <= ap_take && hwrite_i;
      if (ap_take) begin
        rd_addr_r <= haddr_i[7:0];
        wr_addr_r <= haddr_i[7:0];
      end
      if (rd_wait_r) begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (rd_addr_r)
      OFS_CTRL0: rd_mux = {1'b0, chan_sel_r, go_r, on_r};
      OFS_CTRL1: rd_mux = {just_r, clksel_r, 2'b00, pref_r};
      OFS_RES0L: rd_mux = res0l;
      OFS_RES0H: rd_mux = res0h;
      OFS_RES1L: rd_mux = res1l;
      OFS_RES1H: rd_mux = res1h;
      OFS_IRQEN: rd_mux = {1'b0, irqen_r, 6'h00};
      OFS_IRQFL: rd_mux = {1'b0, flag_r, 6'h00};
      OFS_PRE:   rd_mux = {1'b0, pre_cnt_r};
      OFS_ACQ:   rd_mux = {1'b0, acq_cnt_r};
      OFS_CVD:   rd_mux = {1'b0, cvd_r};
      OFS_STAT:  rd_mux = {4'h0, second_r, state_r};
      default:   rd_mux = 8'h00;
    endcase
  end

  // software configuration registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_r      <= 1'b0;
      chan_sel_r <= 5'h00;
      just_r    <= 1'b0;
      clksel_r  <= 3'h0;
      pref_r    <= 2'h0;
      irqen_r   <= 1'b0;
      pre_cnt_r <= 7'h00;
      acq_cnt_r <= 7'h00;
      cvd_r     <= 7'h00;
    end else if (wr_act) begin
      case (wr_addr_r)
        OFS_CTRL0: begin
          on_r  <= hwdata_i[B_ON];
          chan_sel_r <= hwdata_i[B_CHAN +: 5];
        end
        OFS_CTRL1: begin
          just_r   <= hwdata_i[B_JUST];
          clksel_r <= hwdata_i[B_CLKSEL +: 3];
          pref_r   <= hwdata_i[B_PREF +: 2];
        end
        OFS_IRQEN: irqen_r   <= hwdata_i[B_DONE];
        OFS_PRE:   pre_cnt_r <= hwdata_i[6:0];
        OFS_ACQ:   acq_cnt_r <= hwdata_i[6:0];
        OFS_CVD:   cvd_r     <= hwdata_i[6:0];
        default:   ;
      endcase
    end
  end

  assign converter_on_o            = on_r;
  assign input_channel_select_o    = chan_sel_r;
  assign conversion_clock_select_o = clksel_r;
  assign positive_ref_select_o     = pref_r;

  // busy and done flag; the hardware set wins over a software clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_r   <= 1'b0;
      flag_r <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        go_r <= 1'b1;
      end else if (fin || abort) begin
        go_r <= 1'b0;
      end
      if (fin) begin
        flag_r <= 1'b1;
      end else if (wr_act && wr_addr_r == OFS_IRQFL) begin
        flag_r <= hwdata_i[B_DONE];
      end
    end
  end

  // sequencing events
  assign start = ce_i && state_r == ST_IDLE && on_r && (go_set_wr || trig_i);
  assign abort = state_r != ST_IDLE && (!on_r || go_clr_wr);
  assign first_done = state_r == ST_CONV && conv_done_i && !abort && dsen && !second_r;
  assign fin = ce_i && state_r == ST_CONV && conv_done_i && !abort && !(dsen && !second_r);
  // a zero count skips its phase
  assign first_phase = pre_cnt_r != 7'h00 ? ST_PRE : (acq_cnt_r != 7'h00 ? ST_ACQ : ST_CONV);

  // phase state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = first_phase;
        end
      end
      ST_PRE: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (expired) begin
          state_nxt = acq_cnt_r != 7'h00 ? ST_ACQ : ST_CONV;
        end
      end
      ST_ACQ: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (expired) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (conv_done_i) begin
          state_nxt = (dsen && !second_r) ? ST_GAP : ST_IDLE;
        end
      end
      ST_GAP: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (!gap_r) begin
          state_nxt = first_phase;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign second_nxt = start ? 1'b0 : (first_done ? 1'b1 : second_r);
  assign inv_nxt    = second_nxt && ipen;

  // state, sample index and gap counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= ST_IDLE;
      second_r <= 1'b0;
      gap_r    <= 1'b0;
    end else if (ce_i) begin
      state_r  <= state_nxt;
      second_r <= second_nxt;
      gap_r    <= first_done ? GAP_LAST : 1'b0;
    end
  end

  // instruction-cycle tick, realigned at each phase change
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcy_r <= TCY_LAST;
    end else if (ce_i) begin
      if (state_nxt != state_r || tcy_r == {TCY_W{1'b0}}) begin
        tcy_r <= TCY_LAST;
      end else begin
        tcy_r <= tcy_r - {{(TCY_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign tick     = tcy_r == {TCY_W{1'b0}};
  assign tmr_load = state_nxt != state_r && (state_nxt == ST_PRE || state_nxt == ST_ACQ);

  // one timer serves both phases since they never overlap
  cvd_phase_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .load_i    (tmr_load),
    .count_i   (state_nxt == ST_PRE ? pre_cnt_r : acq_cnt_r),
    .tick_i    (tick),
    .expired_o (expired)
  );

  // first sample to pair 0, the inverted second sample to pair 1
  cvd_result_pair u_res0 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .load_i    (ce_i && (first_done || (fin && !second_r))),
    .justify_i (just_r),
    .data_i    (conv_data_i),
    .wr_lo_i   (wr_act && wr_addr_r == OFS_RES0L),
    .wr_hi_i   (wr_act && wr_addr_r == OFS_RES0H),
    .wdata_i   (hwdata_i[7:0]),
    .lo_o      (res0l),
    .hi_o      (res0h)
  );

  cvd_result_pair u_res1 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .load_i    (fin && second_r),
    .justify_i (just_r),
    .data_i    (conv_data_i),
    .wr_lo_i   (wr_act && wr_addr_r == OFS_RES1L),
    .wr_hi_i   (wr_act && wr_addr_r == OFS_RES1H),
    .wdata_i   (hwdata_i[7:0]),
    .lo_o      (res1l),
    .hi_o      (res1h)
  );

  // analog switch controls follow the next state so they change with it
  // idle leaves the capacitor connected and unbiased: its charge carries over
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_connect_o    <= 1'b1;
      hold_bias_en_o    <= 1'b0;
      hold_bias_level_o <= 1'b0;
      sense_drive_o     <= 1'b0;
      sense_drive_oe_o  <= 1'b0;
      conv_start_o      <= 1'b0;
    end else if (ce_i) begin
      hold_connect_o    <= state_nxt != ST_PRE;
      hold_bias_en_o    <= state_nxt == ST_PRE;
      hold_bias_level_o <= cvd_r[B_IPPOL] ^ inv_nxt;
      sense_drive_o     <= cvd_r[B_EPPOL] ^ inv_nxt;
      sense_drive_oe_o  <= state_nxt == ST_PRE;
      conv_start_o      <= state_nxt == ST_CONV && state_r != ST_CONV;
    end
  end

  // guard ring: both set at pre-charge, ring A flips when acquisition starts
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_a_o <= 1'b0;
      guard_b_o <= 1'b0;
    end else if (ce_i) begin
      if (state_nxt == ST_PRE && state_r != ST_PRE) begin
        guard_a_o <= cvd_r[B_GRDPOL] ^ inv_nxt;
        guard_b_o <= cvd_r[B_GRDPOL] ^ inv_nxt;
      end else if (state_nxt == ST_ACQ && state_r != ST_ACQ) begin
        guard_a_o <= ~(cvd_r[B_GRDPOL] ^ inv_nxt);
        guard_b_o <= cvd_r[B_GRDPOL] ^ inv_nxt;
      end
    end
  end

  assign guard_a_oe_o = on_r && cvd_r[B_GAOE];
  assign guard_b_oe_o = on_r && cvd_r[B_GBOE];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_fin;
    fin;
  endsequence

  sequence s_first_done;
    ce_i && first_done;
  endsequence

  property p_pre_pins;
    state_r == ST_PRE |-> !hold_connect_o && hold_bias_en_o && sense_drive_oe_o;
  endproperty
  a_pre_pins: assert property (p_pre_pins) else $error("pre-charge drives wrong");

  property p_acq_pins;
    state_r == ST_ACQ |-> hold_connect_o && !hold_bias_en_o && !sense_drive_oe_o;
  endproperty
  a_acq_pins: assert property (p_acq_pins) else $error("acquisition switches wrong");

  property p_idle_keep;
    state_r == ST_IDLE |-> hold_connect_o && !hold_bias_en_o;
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("hold capacitor disturbed when idle");

  property p_fin;
    s_fin |=> !go_r && flag_r && state_r == ST_IDLE;
  endproperty
  a_fin: assert property (p_fin) else $error("completion did not clear busy and set flag");

  property p_skip_pre;
    start && pre_cnt_r == 7'h00 |=> state_r != ST_PRE && go_r;
  endproperty
  a_skip_pre: assert property (p_skip_pre) else $error("zero pre-charge count not skipped");

  property p_acq_first;
    start && pre_cnt_r == 7'h00 && acq_cnt_r != 7'h00 |=> state_r == ST_ACQ;
  endproperty
  a_acq_first: assert property (p_acq_first) else $error("acquisition did not start on trigger");

  property p_inverted;
    state_r == ST_PRE && second_r && ipen |-> hold_bias_level_o == !cvd_r[B_IPPOL] && sense_drive_o == !cvd_r[B_EPPOL];
  endproperty
  a_inverted: assert property (p_inverted) else $error("second pre-charge not inverted");

  property p_double;
    s_first_done |=> state_r == ST_GAP && second_r && go_r;
  endproperty
  a_double: assert property (p_double) else $error("double sample did not continue");

  property p_conv_start;
    conv_start_o |-> state_r == ST_CONV && $past(state_r) != ST_CONV;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion start out of phase");

  property p_guard;
    state_r == ST_ACQ |-> guard_a_o != guard_b_o;
  endproperty
  a_guard: assert property (p_guard) else $error("guard ring A not flipped in acquisition");
endmodule : cvd_sequencer
`default_nettype wire

// File: cvd_pad_model.sv
`default_nettype none
module cvd_pad_model #(
  parameter logic [9:0] HI_V = 10'h2A5,
  parameter logic [9:0] LO_V = 10'h15A,
  parameter int         LAT  = 12
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       conv_start_i,
  input  wire logic       hold_bias_en_i,
  input  wire logic       hold_bias_level_i,
  output logic            conv_done_o,
  output logic      [9:0] conv_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       lvl_r;
  int         cnt_r;
  logic [9:0] junk_r;
  // hold charge changes only in a bias phase, never at the end of a conversion
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) lvl_r <= 1'b0;
    else if (hold_bias_en_i) lvl_r <= hold_bias_level_i;
  end
  // conversion latency; the data lines churn outside the done cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 0;
      junk_r <= 10'h000;
    end else begin
      junk_r <= ~junk_r;
      if (conv_start_i) cnt_r <= LAT;
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
  end
  assign conv_done_o = (cnt_r == 1);
  assign conv_data_o = conv_done_o ? (lvl_r ? HI_V : LO_V) : junk_r;
endmodule : cvd_pad_model
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top
  import cvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} cvd_row_t;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic        trig      = 1'b0;
  logic        ce        = 1'b1;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic [2:0]  hsize     = 3'h0;
  logic        hready, conv_start, conv_done, on, hconn, hben, hblv, sdrv, sdoe, ga, gaoe, gb, gboe;
  logic [1:0]  hresp, pref;
  logic [31:0] hrdata;
  logic [9:0]  conv_data;
  logic [4:0]  chan;
  logic [2:0]  clks;
  int          fail_count  = 0;
  int          comparisons = 0;
  // ordinary register cases: write a value, read back what sticks
  cvd_row_t    rows [5] = '{'{OFS_CTRL1, 8'hFF, 8'hF3}, '{OFS_PRE, 8'hFF, 8'h7F}, '{OFS_ACQ, 8'h80, 8'h00},
                            '{OFS_IRQEN, 8'hFF, 8'h40}, '{8'h30, 8'hFF, 8'h00}};

  cvd_sequencer DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .trig_i(trig), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .conv_start_o(conv_start), .converter_on_o(on), .input_channel_select_o(chan),
    .conversion_clock_select_o(clks), .positive_ref_select_o(pref), .hold_connect_o(hconn),
    .hold_bias_en_o(hben), .hold_bias_level_o(hblv), .sense_drive_o(sdrv), .sense_drive_oe_o(sdoe),
    .guard_a_o(ga), .guard_a_oe_o(gaoe), .guard_b_o(gb), .guard_b_oe_o(gboe));
  cvd_pad_model PAD (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start),
    .hold_bias_en_i(hben), .hold_bias_level_i(hblv), .conv_done_o(conv_done), .conv_data_o(conv_data));

  // 200 MHz system clock
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single AHB-Lite transfer; read data taken at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rv;
    xfer(1'b1, a, d, rv);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] rv;
    xfer(1'b0, a, 8'h00, rv);
    chk(rv, {24'h000000, e});
  endtask : rc

  // start a sequence, watch the pins by phase, time the start pulse, wait for idle
  task automatic run(input logic use_trig, input int exp_n);
    int          n;
    logic [31:0] rv;
    if (use_trig) begin
      trig <= 1'b1;
      @(posedge clk_sys_i);
      trig <= 1'b0;
    end else wr(OFS_CTRL0, 8'h0F);
    #1;
    n = 0;
    if (exp_n > 41) chk({hconn, hben, hblv, sdoe, sdrv, ga}, 6'b011100);
    else chk(hconn, 1'b1);
    while (conv_start !== 1'b1 && n < 400) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n == 41 && exp_n > 41) chk({hconn, hben, sdoe, ga, gb}, 5'h12);
    end
    chk(n, exp_n);
    // back onto an edge so the polling transfers are driven there
    @(posedge clk_sys_i);
    n = 0;
    do begin
      xfer(1'b0, OFS_STAT, 8'h00, rv);
      n++;
    end while (rv[2:0] != 3'h0 && n < 100);
    // a poll that runs out must not pass silently
    chk({29'h0, rv[2:0]}, 32'h0000_0000);
  endtask : run

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // a full run takes well under 5000 cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 12; i++) rc(8'(i * 4), 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    // right-justified single sample with pre-charge and guard A
    wr(OFS_PRE, 8'h01);
    wr(OFS_ACQ, 8'h01);
    wr(OFS_CVD, 8'h24);
    wr(OFS_CTRL0, 8'h0D);
    // the control write lands at this edge: look once it has settled
    #1;
    chk({on, chan, gaoe}, 7'h47);
    repeat (20) @(posedge clk_sys_i);
    run(1'b0, 82);
    rc(OFS_RES0L, 8'hA5);
    rc(OFS_RES0H, 8'h02);
    rc(OFS_IRQFL, 8'h40);
    rc(OFS_CTRL0, 8'h0D);
    // left-justified, pre-charge skipped, hardware trigger
    wr(OFS_CTRL1, 8'h73);
    wr(OFS_PRE, 8'h00);
    wr(OFS_IRQFL, 8'h00);
    run(1'b1, 41);
    rc(OFS_RES0H, 8'hA9);
    rc(OFS_RES0L, 8'h40);
    // double sample with inversion of the second
    wr(OFS_CTRL1, 8'hF3);
    wr(OFS_PRE, 8'h01);
    wr(OFS_CVD, 8'h07);
    run(1'b0, 82);
    rc(OFS_RES0L, 8'hA5);
    rc(OFS_RES1L, 8'h5A);
    rc(OFS_RES1H, 8'h01);
    rc(OFS_STAT, 8'h08);
    // abort in pre-charge leaves results and flag alone; start without enable is ignored
    wr(OFS_IRQFL, 8'h00);
    wr(OFS_CTRL0, 8'h0F);
    wr(OFS_CTRL0, 8'h0D);
    rc(OFS_STAT, 8'h00);
    rc(OFS_IRQFL, 8'h00);
    rc(OFS_RES0L, 8'hA5);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL0, 8'h02);
    rc(OFS_CTRL0, 8'h00);
    rc(OFS_STAT, 8'h00);
    // a low clock enable freezes a started pre-charge and stalls the bus
    wr(OFS_CVD, 8'h50);
    wr(OFS_CTRL0, 8'h01);
    trig <= 1'b1;
    @(posedge clk_sys_i);
    trig <= 1'b0;
    ce   <= 1'b0;
    repeat (60) @(posedge clk_sys_i);
    chk({hready, hconn, hben, ga, gb, gaoe, gboe, hresp, clks, pref}, 14'h0E9F);
    ce <= 1'b1;
    rc(OFS_STAT, 8'h01);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
